// file: src/axd_threshold_detect.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module axd_threshold_detect (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [axd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [axd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire axd_pkg::axd_sample_s aux_sample,
    output logic aux_activity_event,
    output logic aux_inactivity_event,
    output logic aux_channel_temp
);
    axd_pkg::axd_top_s st;
    axd_pkg::axd_top_s nxt;
    logic [axd_pkg::SAMPLE_W-1:0] mag;
    logic act_qual;
    logic inact_qual;
    logic act_en_eff;
    logic inact_en_eff;
    logic ar_take;
    logic [7:0] ar_idx;

    // Absolute value; -8192 maps to 8192 since the result is unsigned
    function automatic logic [axd_pkg::SAMPLE_W-1:0] magnitude(logic signed [13:0] d);
        return d[13] ? 14'(~d + 14'h1) : 14'(d);
    endfunction : magnitude

    function automatic logic is_mapped(logic [7:0] idx);
        case (idx)
            axd_pkg::IDX_EXT_CTL, axd_pkg::IDX_TEMP_CTL,
            axd_pkg::IDX_ACT_UPPER, axd_pkg::IDX_ACT_LOWER,
            axd_pkg::IDX_INACT_UPPER, axd_pkg::IDX_INACT_LOWER,
            axd_pkg::IDX_TIMER, axd_pkg::IDX_STATUS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_mapped

    function automatic logic [7:0] ctl_byte(axd_pkg::axd_chan_ctl_s c);
        logic [7:0] b;
        b = 8'h00;
        b[axd_pkg::CTL_EN_BIT] = c.en;
        b[axd_pkg::CTL_ACT_BIT] = c.act_en;
        b[axd_pkg::CTL_INACT_BIT] = c.inact_en;
        return b;
    endfunction : ctl_byte

    function automatic axd_pkg::axd_chan_ctl_s ctl_from(logic [7:0] b);
        axd_pkg::axd_chan_ctl_s c;
        c.en = b[axd_pkg::CTL_EN_BIT];
        c.act_en = b[axd_pkg::CTL_ACT_BIT];
        c.inact_en = b[axd_pkg::CTL_INACT_BIT];
        return c;
    endfunction : ctl_from

    // Temperature takes the channel; external enables are then ignored
    function automatic logic chan_enable(axd_pkg::axd_chan_ctl_s t, axd_pkg::axd_chan_ctl_s e,
                                         logic want_act);
        if (t.en) begin
            return want_act ? t.act_en : t.inact_en;
        end
        return e.en && (want_act ? e.act_en : e.inact_en);
    endfunction : chan_enable

    // Reserved bits come back as zero
    function automatic logic [7:0] read_byte(axd_pkg::axd_top_s s, logic [7:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            axd_pkg::IDX_EXT_CTL: b = ctl_byte(s.ext_ctl);
            axd_pkg::IDX_TEMP_CTL: b = ctl_byte(s.temp_ctl);
            axd_pkg::IDX_ACT_UPPER: b[axd_pkg::UPPER_W-1:0] =
                s.act_thr[axd_pkg::THR_W-1:axd_pkg::THR_SPLIT];
            axd_pkg::IDX_ACT_LOWER: b[7:axd_pkg::LOWER_POS] =
                s.act_thr[axd_pkg::THR_SPLIT-1:0];
            axd_pkg::IDX_INACT_UPPER: b[axd_pkg::UPPER_W-1:0] =
                s.inact_thr[axd_pkg::THR_W-1:axd_pkg::THR_SPLIT];
            axd_pkg::IDX_INACT_LOWER: b[7:axd_pkg::LOWER_POS] =
                s.inact_thr[axd_pkg::THR_SPLIT-1:0];
            axd_pkg::IDX_TIMER: b = {s.inact_cnt, s.act_cnt};
            axd_pkg::IDX_STATUS: begin
                b[axd_pkg::ST_ACT] = s.act_seen;
                b[axd_pkg::ST_INACT] = s.inact_seen;
                b[axd_pkg::ST_TEMP] = s.chan_temp;
                b[axd_pkg::ST_LIVE] = s.temp_ctl.en || s.ext_ctl.en;
            end
            default: b = 8'h00;
        endcase
        return b;
    endfunction : read_byte

    // Raw code compare, no range scaling; equal to threshold counts as neither
    assign mag = magnitude(aux_sample.data);
    assign act_qual = mag > {1'b0, st.act_thr};
    assign inact_qual = mag < {1'b0, st.inact_thr};
    assign act_en_eff = chan_enable(st.temp_ctl, st.ext_ctl, 1'b1);
    assign inact_en_eff = chan_enable(st.temp_ctl, st.ext_ctl, 1'b0);
    assign ar_idx = s_axi_araddr[9:2];
    assign ar_take = s_axi_arvalid && st.arready;

    // Register file and bus slave; one write and one read in flight
    always_comb begin
        nxt = st;
        if (s_axi_awvalid && st.awready) begin
            nxt.aw_held = 1'b1;
            nxt.aw_idx = s_axi_awaddr[9:2];
            nxt.aw_ok = (s_axi_awaddr[11:10] == 2'h0) && is_mapped(s_axi_awaddr[9:2]);
        end
        if (s_axi_wvalid && st.wready) begin
            nxt.w_held = 1'b1;
            nxt.wdata = s_axi_wdata[7:0];
            nxt.wstrb0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            nxt.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            nxt.aw_held = 1'b0;
            nxt.w_held = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = st.aw_ok ? axd_pkg::RESP_OKAY : axd_pkg::RESP_SLVERR;
            // Only the low byte lane carries register data
            if (st.aw_ok && st.wstrb0) begin
                case (st.aw_idx)
                    axd_pkg::IDX_EXT_CTL: nxt.ext_ctl = ctl_from(st.wdata);
                    axd_pkg::IDX_TEMP_CTL: nxt.temp_ctl = ctl_from(st.wdata);
                    axd_pkg::IDX_ACT_UPPER: nxt.act_thr[axd_pkg::THR_W-1:axd_pkg::THR_SPLIT] =
                        st.wdata[axd_pkg::UPPER_W-1:0];
                    axd_pkg::IDX_ACT_LOWER: nxt.act_thr[axd_pkg::THR_SPLIT-1:0] =
                        st.wdata[7:axd_pkg::LOWER_POS];
                    axd_pkg::IDX_INACT_UPPER: nxt.inact_thr[axd_pkg::THR_W-1:axd_pkg::THR_SPLIT] =
                        st.wdata[axd_pkg::UPPER_W-1:0];
                    axd_pkg::IDX_INACT_LOWER: nxt.inact_thr[axd_pkg::THR_SPLIT-1:0] =
                        st.wdata[7:axd_pkg::LOWER_POS];
                    axd_pkg::IDX_TIMER: begin
                        nxt.act_cnt = st.wdata[axd_pkg::TMR_INACT_POS-1:0];
                        nxt.inact_cnt = st.wdata[7:axd_pkg::TMR_INACT_POS];
                    end
                    axd_pkg::IDX_STATUS: begin
                        if (st.wdata[axd_pkg::ST_ACT]) nxt.act_seen = 1'b0;
                        if (st.wdata[axd_pkg::ST_INACT]) nxt.inact_seen = 1'b0;
                    end
                    default: ;
                endcase
            end
        end
        // Set after the clear so a same-cycle event is never lost
        if (aux_activity_event) nxt.act_seen = 1'b1;
        if (aux_inactivity_event) nxt.inact_seen = 1'b1;
        nxt.chan_temp = st.temp_ctl.en;
        if (s_axi_rvalid && s_axi_rready) begin
            nxt.rvalid = 1'b0;
        end
        if (ar_take) begin
            nxt.rvalid = 1'b1;
            nxt.rdata = read_byte(st, ar_idx);
            nxt.rresp = ((s_axi_araddr[11:10] == 2'h0) && is_mapped(ar_idx)) ?
                        axd_pkg::RESP_OKAY : axd_pkg::RESP_SLVERR;
        end
        // Readies held low while a transfer waits to be answered
        nxt.awready = !nxt.aw_held && !nxt.bvalid;
        nxt.wready = !nxt.w_held && !nxt.bvalid;
        nxt.arready = !nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= axd_pkg::TOP_RESET;
        end else begin
            st <= nxt;
        end
    end

    // Run counters, one per direction, each with its own count
    axd_run_detect u_act_run (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_valid(aux_sample.valid),
        .qualify(act_qual),
        .enable(act_en_eff),
        .target(st.act_cnt),
        .fire(aux_activity_event)
    );

    axd_run_detect u_inact_run (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_valid(aux_sample.valid),
        .qualify(inact_qual),
        .enable(inact_en_eff),
        .target(st.inact_cnt),
        .fire(aux_inactivity_event)
    );

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = {24'h000000, st.rdata};
    assign aux_channel_temp = st.chan_temp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_act_above;
        aux_activity_event |-> $past(aux_sample.valid && (mag > {1'b0, st.act_thr}));
    endproperty
    a_act_above: assert property (p_act_above) else $error("activity without large sample");

    property p_inact_below;
        aux_inactivity_event |-> $past(aux_sample.valid && (mag < {1'b0, st.inact_thr}));
    endproperty
    a_inact_below: assert property (p_inact_below) else $error("inactivity w/o small sample");

    property p_equal_code;
        aux_sample.valid && mag == {1'b0, st.act_thr} |=> !aux_activity_event;
    endproperty
    a_equal_code: assert property (p_equal_code) else $error("equal code raised activity");

    property p_act_upper_read;
        ar_take && s_axi_araddr == {2'h0, axd_pkg::IDX_ACT_UPPER, 2'h0}
            |=> s_axi_rvalid && s_axi_rdata == {25'h0, $past(st.act_thr[12:6])};
    endproperty
    a_act_upper_read: assert property (p_act_upper_read) else $error("bad act upper read");

    property p_act_lower_read;
        ar_take && s_axi_araddr == {2'h0, axd_pkg::IDX_ACT_LOWER, 2'h0}
            |=> s_axi_rdata == {24'h0, $past(st.act_thr[5:0]), 2'h0};
    endproperty
    a_act_lower_read: assert property (p_act_lower_read) else $error("bad act lower read");

    property p_inact_upper_read;
        ar_take && s_axi_araddr == {2'h0, axd_pkg::IDX_INACT_UPPER, 2'h0}
            |=> s_axi_rdata == {25'h0, $past(st.inact_thr[12:6])};
    endproperty
    a_inact_upper_read: assert property (p_inact_upper_read) else $error("bad inact upper");

    property p_inact_lower_read;
        ar_take && s_axi_araddr == {2'h0, axd_pkg::IDX_INACT_LOWER, 2'h0}
            |=> s_axi_rdata == {24'h0, $past(st.inact_thr[5:0]), 2'h0};
    endproperty
    a_inact_lower_read: assert property (p_inact_lower_read) else $error("bad inact lower");

    property p_temp_owns;
        st.temp_ctl.en && !st.temp_ctl.inact_en |=> aux_channel_temp && !aux_inactivity_event;
    endproperty
    a_temp_owns: assert property (p_temp_owns) else $error("external input leaked through");

    property p_temp_act_gate;
        st.temp_ctl.en && !st.temp_ctl.act_en |=> !aux_activity_event;
    endproperty
    a_temp_act_gate: assert property (p_temp_act_gate) else $error("activity while disabled");

    c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);
    c_act: cover property (aux_activity_event && aux_channel_temp);
    c_inact: cover property (aux_inactivity_event && !aux_channel_temp);
endmodule : axd_threshold_detect
`default_nettype wire

// file: src/axd_pkg.sv
package axd_pkg;
    // Bus and sample geometry
    localparam int ADDR_W = 12;
    localparam int SAMPLE_W = 14;
    localparam int THR_W = 13;
    localparam int CNT_W = 4;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_EXT_CTL = 8'h3c;
    localparam logic [7:0] IDX_TEMP_CTL = 8'h3d;
    localparam logic [7:0] IDX_ACT_UPPER = 8'h3e;
    localparam logic [7:0] IDX_ACT_LOWER = 8'h3f;
    localparam logic [7:0] IDX_INACT_UPPER = 8'h40;
    localparam logic [7:0] IDX_INACT_LOWER = 8'h41;
    localparam logic [7:0] IDX_TIMER = 8'h42;
    localparam logic [7:0] IDX_STATUS = 8'h48;
    // Threshold split: upper byte [6:0] holds [12:6], lower byte [7:2] holds [5:0]
    localparam int THR_SPLIT = 6;
    localparam int UPPER_W = 7;
    localparam int LOWER_POS = 2;
    // Channel control bit positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_ACT_BIT = 1;
    localparam int CTL_INACT_BIT = 3;
    // Timer byte: inactivity count in [7:4], activity count in [3:0]
    localparam int TMR_INACT_POS = 4;
    // Status bit positions
    localparam int ST_ACT = 0;
    localparam int ST_INACT = 1;
    localparam int ST_TEMP = 2;
    localparam int ST_LIVE = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic valid;
        logic signed [SAMPLE_W-1:0] data;
    } axd_sample_s;

    typedef struct packed {
        logic inact_en;
        logic act_en;
        logic en;
    } axd_chan_ctl_s;

    typedef struct packed {
        logic aw_held;
        logic aw_ok;
        logic [7:0] aw_idx;
        logic w_held;
        logic wstrb0;
        logic [7:0] wdata;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        axd_chan_ctl_s ext_ctl;
        axd_chan_ctl_s temp_ctl;
        logic [THR_W-1:0] act_thr;
        logic [THR_W-1:0] inact_thr;
        logic [CNT_W-1:0] act_cnt;
        logic [CNT_W-1:0] inact_cnt;
        logic act_seen;
        logic inact_seen;
        logic chan_temp;
    } axd_top_s;

    typedef struct packed {
        logic [CNT_W-1:0] run;
        logic fire;
    } axd_run_s;

    localparam axd_top_s TOP_RESET = '0;
    localparam axd_run_s RUN_RESET = '0;
endpackage : axd_pkg

// file: src/axd_run_detect.sv
`timescale 1ns/1ps
`default_nettype none
module axd_run_detect (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sample_valid,
    input wire logic qualify,
    input wire logic enable,
    input wire logic [axd_pkg::CNT_W-1:0] target,
    output logic fire
);
    axd_pkg::axd_run_s st;
    axd_pkg::axd_run_s nxt;
    logic [axd_pkg::CNT_W-1:0] eff;

    // A zero count still needs one qualifying sample
    assign eff = (target == 4'h0) ? 4'h1 : target;

    // Consecutive run; fires once when the run reaches the count
    always_comb begin
        nxt = st;
        nxt.fire = 1'b0;
        if (!enable) begin
            nxt.run = 4'h0;
        end else if (sample_valid) begin
            if (qualify) begin
                nxt.run = (st.run == 4'hf) ? st.run : st.run + 4'h1;
                // A run parked at a count of 15 must not fire again
                nxt.fire = (nxt.run == eff) && (st.run != eff);
            end else begin
                nxt.run = 4'h0; // Run broken, start over
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= axd_pkg::RUN_RESET;
        end else begin
            st <= nxt;
        end
    end

    assign fire = st.fire;

    property p_fire_run;
        @(posedge aclk) disable iff (!aresetn)
        fire |-> st.run == $past(eff) && $past(sample_valid && qualify && enable);
    endproperty
    a_fire_run: assert property (p_fire_run) else $error("event without full run");

    c_fire: cover property (@(posedge aclk) disable iff (!aresetn) fire && target > 4'h2);
endmodule : axd_run_detect
`default_nettype wire

// file: tb/axd_threshold_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Compares two values, counts the comparison and reports a mismatch at once
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module axd_threshold_detect_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [axd_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    axd_pkg::axd_sample_s aux_sample = '0;
    logic act_ev, inact_ev, chan_temp;
    int error_cnt = 0, checked = 0, cyc = 0;
    logic [31:0] seed = 32'h1b27b576;
    // Reference state kept with plain integers
    int m_ext, m_temp, m_at, m_it, m_tm, run_a, run_i;
    logic ea, ei, seen_a, seen_i;

    always #2.5 aclk = ~aclk;

    axd_threshold_detect dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .aux_sample(aux_sample),
        .aux_activity_event(act_ev), .aux_inactivity_event(inact_ev),
        .aux_channel_temp(chan_temp)
    );

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            summarize();
        end
    end

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    // Write offers address and data together; each is released once taken
    task automatic axw(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                       input logic [1:0] exp_resp);
        int n;
        n = 0;
        awaddr <= ba(idx);
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= s;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        `CHK(bresp, exp_resp)
    endtask : axw

    task automatic axr(input logic [7:0] idx, input logic [7:0] exp_d,
                       input logic [1:0] exp_resp, input logic [7:0] mask);
        int n;
        n = 0;
        araddr <= ba(idx);
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        `CHK(rresp, exp_resp)
        `CHK(rdata & {24'hffffff, mask}, {24'h0, exp_d & mask})
    endtask : axr

    // Reference run counters; a disabled channel clears its run
    task automatic model(input logic v, input int d);
        int m, ta, ti, old;
        logic act_on, inact_on;
        ea = 1'b0;
        ei = 1'b0;
        if (!v) return;
        m = (d < 0) ? -d : d;
        ta = ((m_tm & 15) == 0) ? 1 : (m_tm & 15);
        ti = ((m_tm >> 4) == 0) ? 1 : (m_tm >> 4);
        act_on = m_temp[0] ? m_temp[1] : (m_ext[0] & m_ext[1]);
        inact_on = m_temp[0] ? m_temp[3] : (m_ext[0] & m_ext[3]);
        old = run_a;
        run_a = (act_on && m > m_at) ? ((run_a < 15) ? run_a + 1 : 15) : 0;
        ea = (run_a == ta && old != ta);
        old = run_i;
        run_i = (inact_on && m < m_it) ? ((run_i < 15) ? run_i + 1 : 15) : 0;
        ei = (run_i == ti && old != ti);
        seen_a |= ea;
        seen_i |= ei;
    endtask : model

    // One test: reset, configure, stream samples, check every cycle and the status
    task automatic phase(input int k, input int ec, input int tc, input int at, input int it,
                         input int tm, input int mode, input int n);
        logic pv, nv;
        int pd, nd, base;
        logic [31:0] r;
        logic [7:0] st_exp;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(axd_pkg::IDX_ACT_UPPER, 8'h00, axd_pkg::RESP_OKAY, 8'hff);
        axr(axd_pkg::IDX_ACT_LOWER, 8'h00, axd_pkg::RESP_OKAY, 8'hff);
        axr(axd_pkg::IDX_INACT_UPPER, 8'h00, axd_pkg::RESP_OKAY, 8'hff);
        axr(axd_pkg::IDX_INACT_LOWER, 8'h00, axd_pkg::RESP_OKAY, 8'hff);
        m_ext = ec;
        m_temp = tc;
        m_at = at;
        m_it = it;
        m_tm = tm;
        run_a = 0;
        run_i = 0;
        {seen_a, seen_i} = 2'b00;
        r = xs();
        axw(axd_pkg::IDX_EXT_CTL, 8'(ec), 4'h1, axd_pkg::RESP_OKAY);
        axw(axd_pkg::IDX_TEMP_CTL, 8'(tc), 4'h1, axd_pkg::RESP_OKAY);
        axw(axd_pkg::IDX_TIMER, 8'(tm), 4'h1, axd_pkg::RESP_OKAY);
        // Reserved bits are written with junk; they must still read zero
        axw(axd_pkg::IDX_ACT_UPPER, {r[0], 7'(at >> 6)}, 4'h1, axd_pkg::RESP_OKAY);
        axw(axd_pkg::IDX_ACT_LOWER, {6'(at), r[2:1]}, 4'h1, axd_pkg::RESP_OKAY);
        axw(axd_pkg::IDX_INACT_UPPER, {r[3], 7'(it >> 6)}, 4'h1, axd_pkg::RESP_OKAY);
        axw(axd_pkg::IDX_INACT_LOWER, {6'(it), r[5:4]}, 4'h1, axd_pkg::RESP_OKAY);
        axr(axd_pkg::IDX_ACT_UPPER, 8'(at >> 6), axd_pkg::RESP_OKAY, 8'hff);
        axr(axd_pkg::IDX_ACT_LOWER, {6'(at), 2'b00}, axd_pkg::RESP_OKAY, 8'hff);
        axr(axd_pkg::IDX_INACT_UPPER, 8'(it >> 6), axd_pkg::RESP_OKAY, 8'hff);
        axr(axd_pkg::IDX_INACT_LOWER, {6'(it), 2'b00}, axd_pkg::RESP_OKAY, 8'hff);
        axr(axd_pkg::IDX_TIMER, 8'(tm), axd_pkg::RESP_OKAY, 8'hff);
        axr(axd_pkg::IDX_TEMP_CTL, 8'(tc), axd_pkg::RESP_OKAY, 8'h0b);
        axr(axd_pkg::IDX_EXT_CTL, 8'(ec), axd_pkg::RESP_OKAY, 8'h0b);
        pv = 1'b0;
        pd = 0;
        for (int i = 0; i <= n; i++) begin
            @(posedge aclk);
            model(pv, pd);
            r = xs();
            nv = (i < n) && (mode == 1 || r[0]);
            if (mode == 0) begin
                nd = int'(r[20:7]) - 8192;
            end else begin
                // Near either threshold, one code either side
                base = r[1] ? at : it;
                nd = base + int'(r[9:8] % 3) - 1;
                nd = (nd == 8192) ? -8192 : (r[2] ? -nd : nd);
            end
            aux_sample <= '{valid: nv, data: 14'(nd)};
            #1;
            `CHK(act_ev, ea)
            `CHK(inact_ev, ei)
            `CHK(chan_temp, tc[0])
            pv = nv;
            pd = nd;
        end
        // One more edge, so an event of the last sample has reached the status
        @(posedge aclk);
        st_exp = {4'h0, ec[0] | tc[0], tc[0], seen_i, seen_a};
        axr(axd_pkg::IDX_STATUS, st_exp, axd_pkg::RESP_OKAY, 8'h0f);
        // Writing ones clears both seen bits; nothing is streaming to set them again
        axw(axd_pkg::IDX_STATUS, 8'h03, 4'h1, axd_pkg::RESP_OKAY);
        axr(axd_pkg::IDX_STATUS, {st_exp[7:2], 2'b00}, axd_pkg::RESP_OKAY, 8'h0f);
        $display("test %0d done", k);
    endtask : phase

    initial begin
        repeat (8) @(posedge aclk);
        phase(1, 'h0b, 'h00, 3000, 2500, 'h32, 0, 300);
        phase(2, 'h0b, 'h00, int'(xs() % 8192), int'(xs() % 8192), 'h00, 1, 300);
        phase(3, 'h0b, 'h03, 100, 4000, 'h11, 1, 200);
        phase(4, 'h0b, 'h09, 200, 300, 'h21, 1, 200);
        phase(5, 'h0b, 'h01, 200, 300, 'h11, 1, 150);
        phase(6, 'h0b, 'h00, 0, 8191, 'hff, 1, 300);
        phase(7, 'h03, 'h00, 8191, 8191, 'h00, 1, 200);
        phase(8, 'h0a, 'h00, 100, 200, 'h11, 1, 150);
        // Write with no byte strobe leaves the threshold alone
        axw(axd_pkg::IDX_ACT_UPPER, 8'h55, 4'h0, axd_pkg::RESP_OKAY);
        axr(axd_pkg::IDX_ACT_UPPER, 8'h01, axd_pkg::RESP_OKAY, 8'hff);
        // Unmapped index answers with an error and reads zero
        axw(8'h11, 8'haa, 4'h1, axd_pkg::RESP_SLVERR);
        axr(8'h11, 8'h00, axd_pkg::RESP_SLVERR, 8'hff);
        $display("test 9 done");
        summarize();
    end
endmodule : axd_threshold_detect_tb
`default_nettype wire
